// File: hdl/tmc_timer.sv
// Design: 8-bit timer/counter with one compare channel and APB slave
//
// Overview of operation
// - Clock select zero gives no tick; the counter holds its value.
// - Each tick clears the counter or steps it by one up or down.
// - Count value readable and writable at any time.
// - A count write beats any clear or count in that cycle.
// - Two waveform mode bits select the counting sequence.
// - Overflow flag set at the mode's overflow point; usable as interrupt.
// - Eight-bit comparator flags match whenever count equals compare.
// - Match sets compare flag at the following tick.
// - Compare interrupt needs flag, enable bit and global enable.
// - Compare flag clears on service or on written one.
// - Output derived from match, modes, top and bottom.
// - Compare value double buffered only in PWM modes.
// - Buffered compare moves to active register at top only.
// - Software compare access goes to buffer when buffered, else active.
// - Force strobe updates output in non-PWM modes; no flag, no clear.
// - A count write blocks compare matches in the next tick cycle.
// - Output state kept across waveform mode changes.
// - Compare output mode bits act immediately, not buffered.
// - Output mode sets match action and whether the pin is driven.
// - Reset clears the output state to zero.
// - Bottom is 0x00, max 0xFF, top is max or compare.
// - Output mode zero leaves the output state untouched at match.
`timescale 1ns/1ns
`default_nettype none

module tmc_timer
  import tmc_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // External tick source, synchronous
  input  wire logic        ext_clk_in,
  // Processor side interrupt handshake
  input  wire logic        global_irq_enable,
  input  wire logic        cmp_irq_ack,
  input  wire logic        ovf_irq_ack,
  output var  logic        cmp_irq,
  output var  logic        ovf_irq,
  // Compare output pin
  output var  logic        compare_output,
  output var  logic        compare_output_en
);

  // ****************************************
  // Reset release
  // ****************************************
  logic rst_meta_ff;
  logic rst_sync_ff;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // ****************************************
  // Registers and state
  // ****************************************
  tmc_ctrl_t  ctrl_ff;
  logic [7:0] count_value_ff;
  logic [7:0] compare_value_ff;
  logic [7:0] cmp_buf_ff;
  logic       overflow_flag_ff;
  logic       compare_match_flag_ff;
  logic       compare_irq_enable_ff;
  logic       overflow_irq_enable_ff;
  logic       oc_state_ff;
  logic       dir_down_ff;
  logic       block_ff;
  logic [9:0] prescale_ff;
  logic       ext_prev_ff;

  // ****************************************
  // Decode helpers
  // ****************************************
  function automatic logic is_pwm(input logic [1:0] m);
    is_pwm = (m == TMC_WGM_PCPWM) || (m == TMC_WGM_FAST);
  endfunction

  function automatic logic bus_wr(input logic [11:0] a);
    bus_wr = psel && penable && pwrite && (paddr == a);
  endfunction

  logic       acc;
  logic       wr_ctrl;
  logic       wr_count;
  logic       wr_cmp;
  logic       wr_flag;
  logic       wr_mask;
  logic       force_req;
  logic       pwm_mode;
  logic [1:0] wgm;
  logic [1:0] com;

  assign acc       = psel && penable;
  assign wr_ctrl   = bus_wr(TMC_CTRL_ADDR);
  assign wr_count  = bus_wr(TMC_COUNT_ADDR);
  assign wr_cmp    = bus_wr(TMC_CMP_ADDR);
  assign wr_flag   = bus_wr(TMC_FLAG_ADDR);
  assign wr_mask   = bus_wr(TMC_MASK_ADDR);
  assign wgm       = ctrl_ff.waveform_gen_mode;
  assign com       = ctrl_ff.compare_output_mode;
  assign pwm_mode  = is_pwm(wgm);
  assign force_req = wr_ctrl && pwdata[TMC_FORCE_BIT]
                     && !is_pwm({pwdata[TMC_WGM_HI], pwdata[TMC_WGM_LO]});

  // ****************************************
  // Tick generation
  // ****************************************
  // Prescaler free-runs so tick phase is independent of count writes
  logic tick;
  logic ext_rise;

  assign ext_rise = ext_clk_in && !ext_prev_ff;

  always_ff @(posedge sys_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      prescale_ff <= 10'h000;
      ext_prev_ff <= 1'b0;
    end else begin
      prescale_ff <= prescale_ff + 10'h001;
      ext_prev_ff <= ext_clk_in;
    end
  end

  always_comb begin
    case (ctrl_ff.clock_source_select)
      TMC_CS_STOP:  tick = 1'b0;
      TMC_CS_DIV1:  tick = 1'b1;
      TMC_CS_DIV8:  tick = (prescale_ff[2:0] == TMC_PS_M8[2:0]);
      TMC_CS_DIV64: tick = (prescale_ff[5:0] == TMC_PS_M64[5:0]);
      TMC_CS_D256:  tick = (prescale_ff[7:0] == TMC_PS_M256[7:0]);
      TMC_CS_D1024: tick = (prescale_ff == TMC_PS_M1024);
      TMC_CS_EXTF:  tick = !ext_clk_in && ext_prev_ff;
      default:      tick = ext_rise;
    endcase
  end

  // ****************************************
  // Counter unit
  // ****************************************
  logic [7:0] top_val;
  logic       at_top;
  logic       at_bottom;
  logic       match;

  assign top_val   = (wgm == TMC_WGM_CTC) ? compare_value_ff : TMC_MAX;
  assign at_top    = (count_value_ff == top_val);
  assign at_bottom = (count_value_ff == TMC_BOTTOM);
  assign match     = (count_value_ff == compare_value_ff);

  always_ff @(posedge sys_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      count_value_ff <= TMC_BOTTOM;
    end else if (wr_count) begin
      count_value_ff <= pwdata[7:0];
    end else if (tick) begin
      case (wgm)
        TMC_WGM_CTC:   count_value_ff <= match ? TMC_BOTTOM : count_value_ff + TMC_ONE;
        TMC_WGM_PCPWM: count_value_ff <= (at_top || (dir_down_ff && !at_bottom))
                                         ? count_value_ff - TMC_ONE
                                         : count_value_ff + TMC_ONE;
        default:       count_value_ff <= count_value_ff + TMC_ONE;
      endcase
    end
  end

  // Direction for phase correct mode: turn at max and bottom
  always_ff @(posedge sys_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      dir_down_ff <= 1'b0;
    end else if (wgm != TMC_WGM_PCPWM) begin
      dir_down_ff <= 1'b0;
    end else if (tick && !wr_count) begin
      if (at_top) begin
        dir_down_ff <= 1'b1;
      end else if (at_bottom) begin
        dir_down_ff <= 1'b0;
      end
    end
  end

  // Blocks matches through the tick cycle after a count write
  always_ff @(posedge sys_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      block_ff <= 1'b0;
    end else if (wr_count) begin
      block_ff <= 1'b1;
    end else if (tick) begin
      block_ff <= 1'b0;
    end
  end

  logic match_ok;
  assign match_ok = match && !block_ff && tick;

  // ****************************************
  // Compare register, double buffered
  // ****************************************
  logic reload;
  assign reload = (wgm == TMC_WGM_FAST) ? (tick && at_top) : (tick && at_top && !wr_count);

  always_ff @(posedge sys_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      compare_value_ff <= TMC_BOTTOM;
      cmp_buf_ff       <= TMC_BOTTOM;
    end else begin
      if (wr_cmp) begin
        cmp_buf_ff <= pwdata[7:0];
      end
      if (!pwm_mode) begin
        if (wr_cmp) begin
          compare_value_ff <= pwdata[7:0];
        end
      end else if (reload) begin
        compare_value_ff <= cmp_buf_ff;
      end
    end
  end

  // ****************************************
  // Flags and interrupts
  // ****************************************
  logic ovf_evt;
  assign ovf_evt = tick && !wr_count &&
                   ((wgm == TMC_WGM_PCPWM) ? (at_bottom && dir_down_ff) : at_top);

  always_ff @(posedge sys_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      overflow_flag_ff      <= 1'b0;
      compare_match_flag_ff <= 1'b0;
    end else begin
      // Set wins over any clear in the same cycle
      if (ovf_evt) begin
        overflow_flag_ff <= 1'b1;
      end else if (ovf_irq_ack || (wr_flag && pwdata[TMC_OVF_BIT])) begin
        overflow_flag_ff <= 1'b0;
      end
      if (match_ok) begin
        compare_match_flag_ff <= 1'b1;
      end else if (cmp_irq_ack || (wr_flag && pwdata[TMC_CMP_BIT])) begin
        compare_match_flag_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      compare_irq_enable_ff  <= 1'b0;
      overflow_irq_enable_ff <= 1'b0;
      cmp_irq                <= 1'b0;
      ovf_irq                <= 1'b0;
    end else begin
      if (wr_mask) begin
        compare_irq_enable_ff  <= pwdata[TMC_CMP_BIT];
        overflow_irq_enable_ff <= pwdata[TMC_OVF_BIT];
      end
      cmp_irq <= compare_match_flag_ff && compare_irq_enable_ff && global_irq_enable
                 && !cmp_irq_ack;
      ovf_irq <= overflow_flag_ff && overflow_irq_enable_ff && global_irq_enable
                 && !ovf_irq_ack;
    end
  end

  // ****************************************
  // Control register
  // ****************************************
  always_ff @(posedge sys_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      ctrl_ff <= '0;
    end else if (wr_ctrl) begin
      ctrl_ff.clock_source_select <= pwdata[TMC_CS_LSB +: 3];
      ctrl_ff.waveform_gen_mode   <= {pwdata[TMC_WGM_HI], pwdata[TMC_WGM_LO]};
      ctrl_ff.compare_output_mode <= pwdata[TMC_COM_LSB +: 2];
    end
  end

  // ****************************************
  // Waveform generator
  // ****************************************
  // Output state is never touched by a mode change, only by events
  logic nxt_oc_state;

  always_comb begin
    nxt_oc_state = oc_state_ff;
    if (force_req) begin
      case (pwdata[TMC_COM_LSB +: 2])
        TMC_COM_TOGGLE: nxt_oc_state = !oc_state_ff;
        TMC_COM_CLEAR:  nxt_oc_state = 1'b0;
        TMC_COM_SET:    nxt_oc_state = 1'b1;
        default:        nxt_oc_state = oc_state_ff;
      endcase
    end else if (tick && !wr_count) begin
      case (wgm)
        TMC_WGM_FAST: begin
          if (com[1] && match_ok) begin
            nxt_oc_state = com[0];
          end else if (com[1] && at_top) begin
            nxt_oc_state = !com[0];
          end
        end
        TMC_WGM_PCPWM: begin
          if (com[1] && match_ok) begin
            nxt_oc_state = dir_down_ff ? !com[0] : com[0];
          end else if (com[1] && at_bottom) begin
            nxt_oc_state = !com[0];
          end
        end
        default: begin
          if (match_ok) begin
            case (com)
              TMC_COM_TOGGLE: nxt_oc_state = !oc_state_ff;
              TMC_COM_CLEAR:  nxt_oc_state = 1'b0;
              TMC_COM_SET:    nxt_oc_state = 1'b1;
              default:        nxt_oc_state = oc_state_ff;
            endcase
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      oc_state_ff       <= 1'b0;
      compare_output    <= 1'b0;
      compare_output_en <= 1'b0;
    end else begin
      oc_state_ff       <= nxt_oc_state;
      compare_output    <= nxt_oc_state;
      compare_output_en <= (com != TMC_COM_OFF);
    end
  end

  // ****************************************
  // APB slave
  // ****************************************
  logic [31:0] nxt_prdata;
  logic        mapped;

  always_comb begin
    nxt_prdata = TMC_ZERO32;
    mapped     = 1'b1;
    case (paddr)
      TMC_CTRL_ADDR: begin
        nxt_prdata[TMC_CS_LSB +: 3]  = ctrl_ff.clock_source_select;
        nxt_prdata[TMC_WGM_LO]       = ctrl_ff.waveform_gen_mode[0];
        nxt_prdata[TMC_WGM_HI]       = ctrl_ff.waveform_gen_mode[1];
        nxt_prdata[TMC_COM_LSB +: 2] = ctrl_ff.compare_output_mode;
      end
      TMC_COUNT_ADDR: nxt_prdata[7:0] = count_value_ff;
      TMC_CMP_ADDR:   nxt_prdata[7:0] = pwm_mode ? cmp_buf_ff : compare_value_ff;
      TMC_FLAG_ADDR: begin
        nxt_prdata[TMC_OVF_BIT] = overflow_flag_ff;
        nxt_prdata[TMC_CMP_BIT] = compare_match_flag_ff;
      end
      TMC_MASK_ADDR: begin
        nxt_prdata[TMC_OVF_BIT] = overflow_irq_enable_ff;
        nxt_prdata[TMC_CMP_BIT] = compare_irq_enable_ff;
      end
      default: mapped = 1'b0;
    endcase
  end

  // Zero wait states; pready flop is held high in every cycle
  always_ff @(posedge sys_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      prdata  <= TMC_ZERO32;
      pready  <= 1'b1;
      pslverr <= 1'b0;
    end else begin
      prdata  <= (psel && !penable && !pwrite) ? nxt_prdata : prdata;
      pready  <= 1'b1;
      pslverr <= psel && !penable && !mapped;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  sequence s_count_write;
    wr_count ##1 1'b1;
  endsequence

  AST_STOP_HOLDS: assert property (@(posedge sys_clk) disable iff (!rst_sync_ff)
    (ctrl_ff.clock_source_select == TMC_CS_STOP && !wr_count)
      |=> $stable(count_value_ff))
    else $error("Counter moved while stopped");

  AST_WRITE_WINS: assert property (@(posedge sys_clk) disable iff (!rst_sync_ff)
    wr_count |=> count_value_ff == $past(pwdata[7:0]))
    else $error("Count write lost");

  AST_STEP_ONE: assert property (@(posedge sys_clk) disable iff (!rst_sync_ff)
    (tick && !wr_count && wgm == TMC_WGM_NORMAL)
      |=> count_value_ff == $past(count_value_ff) + TMC_ONE)
    else $error("Normal mode step wrong");

  AST_FLAG_SET: assert property (@(posedge sys_clk) disable iff (!rst_sync_ff)
    match_ok |=> compare_match_flag_ff)
    else $error("Compare flag not set");

  AST_BLOCK: assert property (@(posedge sys_clk) disable iff (!rst_sync_ff)
    s_count_write |-> !match_ok)
    else $error("Match not blocked after count write");

  AST_IRQ: assert property (@(posedge sys_clk) disable iff (!rst_sync_ff)
    cmp_irq |-> $past(compare_match_flag_ff && compare_irq_enable_ff && global_irq_enable))
    else $error("Compare irq without cause");

  AST_ACK_CLEAR: assert property (@(posedge sys_clk) disable iff (!rst_sync_ff)
    (cmp_irq_ack && !match_ok) |=> !compare_match_flag_ff)
    else $error("Compare flag not cleared");

  AST_NO_BUF: assert property (@(posedge sys_clk) disable iff (!rst_sync_ff)
    (wr_cmp && !pwm_mode) |=> compare_value_ff == $past(pwdata[7:0]))
    else $error("Compare not direct in non-PWM");

  AST_FORCE: assert property (@(posedge sys_clk) disable iff (!rst_sync_ff)
    (force_req && pwdata[TMC_COM_LSB +: 2] == TMC_COM_SET) |=> oc_state_ff ##0
      $stable(compare_match_flag_ff) || $past(match_ok))
    else $error("Force did not set output");

  AST_COM_OFF: assert property (@(posedge sys_clk) disable iff (!rst_sync_ff)
    (com == TMC_COM_OFF && !force_req && !pwm_mode) |=> $stable(oc_state_ff))
    else $error("Output changed with mode zero");

endmodule

`default_nettype wire

// File: common/tmc_pkg.sv
// Package: register map, field layout and mode encodings of the 8-bit timer
package tmc_pkg;

  // ****************************************
  // Register byte addresses
  // ****************************************
  localparam logic [11:0] TMC_CTRL_ADDR  = 12'h000;
  localparam logic [11:0] TMC_COUNT_ADDR = 12'h004;
  localparam logic [11:0] TMC_CMP_ADDR   = 12'h008;
  localparam logic [11:0] TMC_FLAG_ADDR  = 12'h00C;
  localparam logic [11:0] TMC_MASK_ADDR  = 12'h010;

  // ****************************************
  // Control register fields
  // ****************************************
  localparam int TMC_CS_LSB    = 0;
  localparam int TMC_WGM_LO    = 3;
  localparam int TMC_WGM_HI    = 6;
  localparam int TMC_COM_LSB   = 4;
  localparam int TMC_FORCE_BIT = 7;

  // Flag / mask bit positions
  localparam int TMC_OVF_BIT   = 0;
  localparam int TMC_CMP_BIT   = 1;

  // ****************************************
  // Values
  // ****************************************
  localparam logic [7:0] TMC_BOTTOM   = 8'h00;
  localparam logic [7:0] TMC_MAX      = 8'hFF;
  localparam logic [2:0] TMC_CS_STOP  = 3'h0;
  localparam logic [2:0] TMC_CS_DIV1  = 3'h1;
  localparam logic [2:0] TMC_CS_DIV8  = 3'h2;
  localparam logic [2:0] TMC_CS_DIV64 = 3'h3;
  localparam logic [2:0] TMC_CS_D256  = 3'h4;
  localparam logic [2:0] TMC_CS_D1024 = 3'h5;
  localparam logic [2:0] TMC_CS_EXTF  = 3'h6;
  localparam logic [9:0] TMC_PS_M8    = 10'h007;
  localparam logic [9:0] TMC_PS_M64   = 10'h03F;
  localparam logic [9:0] TMC_PS_M256  = 10'h0FF;
  localparam logic [9:0] TMC_PS_M1024 = 10'h3FF;
  localparam logic [7:0] TMC_ONE      = 8'h01;
  localparam logic [31:0] TMC_ZERO32  = 32'h0000_0000;

  // Waveform generation modes
  localparam logic [1:0] TMC_WGM_NORMAL = 2'h0;
  localparam logic [1:0] TMC_WGM_PCPWM  = 2'h1;
  localparam logic [1:0] TMC_WGM_CTC    = 2'h2;
  localparam logic [1:0] TMC_WGM_FAST   = 2'h3;

  // Compare output modes
  localparam logic [1:0] TMC_COM_OFF    = 2'h0;
  localparam logic [1:0] TMC_COM_TOGGLE = 2'h1;
  localparam logic [1:0] TMC_COM_CLEAR  = 2'h2;
  localparam logic [1:0] TMC_COM_SET    = 2'h3;

  // Control fields as one carrier
  typedef struct packed {
    logic [1:0] waveform_gen_mode;
    logic [1:0] compare_output_mode;
    logic [2:0] clock_source_select;
  } tmc_ctrl_t;

endpackage

// File: verification/tmc_timer_tb_top.sv
// Testbench: self-checking bench for the 8-bit timer/counter
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin error_cnt++; $display("BAD t=%0t got %0h exp %0h", $time, got, exp); end end

module tmc_timer_tb_top;
  import tmc_pkg::*;

  // ****************************************
  // Signals
  // ****************************************
  logic        sys_clk;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        ext_clk_in;
  logic        global_irq_enable;
  logic        cmp_irq_ack;
  logic        ovf_irq_ack;
  logic        cmp_irq;
  logic        ovf_irq;
  logic        compare_output;
  logic        compare_output_en;
  logic [31:0] rv;
  logic        rerr;
  int          error_cnt;
  int          check_count;
  int          cyc;

  // Rising edge of the external input is the only tick source used
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  localparam logic [1:0] FRC_COM [4] = '{TMC_COM_SET, TMC_COM_TOGGLE, TMC_COM_CLEAR, TMC_COM_TOGGLE};
  localparam logic       FRC_OC  [4] = '{1'b1, 1'b0, 1'b0, 1'b1};

  tmc_timer i_dut (
    .sys_clk           (sys_clk),
    .rst_n             (rst_n),
    .psel              (psel),
    .penable           (penable),
    .pwrite            (pwrite),
    .paddr             (paddr),
    .pwdata            (pwdata),
    .prdata            (prdata),
    .pready            (pready),
    .pslverr           (pslverr),
    .ext_clk_in        (ext_clk_in),
    .global_irq_enable (global_irq_enable),
    .cmp_irq_ack       (cmp_irq_ack),
    .ovf_irq_ack       (ovf_irq_ack),
    .cmp_irq           (cmp_irq),
    .ovf_irq           (ovf_irq),
    .compare_output    (compare_output),
    .compare_output_en (compare_output_en)
  );

  initial sys_clk = 1'b0;
  always #25 sys_clk = ~sys_clk;

  // Hang guard, well above the few hundred cycles the run needs
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc > 20000) begin
      error_cnt++;
      end_of_test();
    end
  end

  // ****************************************
  // Bus and stimulus helpers
  // ****************************************
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) error_cnt++;
    rv      = prdata;
    rerr    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, TMC_ZERO32);
  endtask

  // Synchronous input: held long enough for any edge detector
  task automatic tick();
    @(posedge sys_clk);
    ext_clk_in <= 1'b1;
    repeat (4) @(posedge sys_clk);
    ext_clk_in <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask

  function automatic logic [31:0] ctl(input logic [2:0] cs, input logic [1:0] wgm,
                                      input logic [1:0] com, input logic frc);
    logic [31:0] v;
    v = TMC_ZERO32;
    v[2:0] = cs;
    v[TMC_WGM_LO] = wgm[0];
    v[TMC_WGM_HI] = wgm[1];
    v[5:4] = com;
    v[TMC_FORCE_BIT] = frc;
    return v;
  endfunction

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    `CHK(compare_output, 1'b0)
    `CHK(compare_output_en, 1'b0)
    `CHK(pready, 1'b1)
    rd(12'h020);
    `CHK(rerr, 1'b1)
    `CHK(rv, TMC_ZERO32)
    $display("test reset done");
  endtask

  task automatic t_stop();
    wr(TMC_CTRL_ADDR, ctl(TMC_CS_STOP, TMC_WGM_NORMAL, TMC_COM_OFF, 1'b0));
    wr(TMC_COUNT_ADDR, 32'h0000_0010);
    tick();
    tick();
    rd(TMC_COUNT_ADDR);
    `CHK(rv, 32'h0000_0010)
    $display("test stop done");
  endtask

  task automatic t_ovf();
    wr(TMC_CTRL_ADDR, ctl(CS_EXT_RISE, TMC_WGM_NORMAL, TMC_COM_OFF, 1'b0));
    wr(TMC_COUNT_ADDR, 32'h0000_00FE);
    tick();
    rd(TMC_COUNT_ADDR);
    `CHK(rv[7:0], TMC_MAX)
    tick();
    rd(TMC_COUNT_ADDR);
    `CHK(rv[7:0], TMC_BOTTOM)
    rd(TMC_FLAG_ADDR);
    `CHK(rv[TMC_OVF_BIT], 1'b1)
    wr(TMC_MASK_ADDR, 32'h0000_0001);
    global_irq_enable <= 1'b1;
    repeat (2) @(posedge sys_clk);
    `CHK(ovf_irq, 1'b1)
    ovf_irq_ack <= 1'b1;
    @(posedge sys_clk);
    ovf_irq_ack <= 1'b0;
    repeat (2) @(posedge sys_clk);
    `CHK(ovf_irq, 1'b0)
    $display("test overflow done");
  endtask

  task automatic t_cmp();
    wr(TMC_CMP_ADDR, 32'h0000_0005);
    wr(TMC_COUNT_ADDR, 32'h0000_0003);
    wr(TMC_FLAG_ADDR, 32'h0000_0003);
    wr(TMC_MASK_ADDR, 32'h0000_0002);
    global_irq_enable <= 1'b0;
    tick();
    tick();
    rd(TMC_FLAG_ADDR);
    `CHK(rv[TMC_CMP_BIT], 1'b0)
    tick();
    rd(TMC_FLAG_ADDR);
    `CHK(rv[TMC_CMP_BIT], 1'b1)
    `CHK(cmp_irq, 1'b0)
    global_irq_enable <= 1'b1;
    repeat (2) @(posedge sys_clk);
    `CHK(cmp_irq, 1'b1)
    wr(TMC_FLAG_ADDR, 32'h0000_0002);
    repeat (2) @(posedge sys_clk);
    `CHK(cmp_irq, 1'b0)
    // Count written equal to compare: the match must be swallowed
    wr(TMC_COUNT_ADDR, 32'h0000_0005);
    tick();
    tick();
    rd(TMC_FLAG_ADDR);
    `CHK(rv[TMC_CMP_BIT], 1'b0)
    rd(TMC_COUNT_ADDR);
    `CHK(rv[7:0], 8'h07)
    $display("test compare done");
  endtask

  task automatic t_ctc();
    wr(TMC_CTRL_ADDR, ctl(CS_EXT_RISE, TMC_WGM_CTC, TMC_COM_OFF, 1'b0));
    wr(TMC_CMP_ADDR, 32'h0000_0002);
    rd(TMC_CMP_ADDR);
    `CHK(rv[7:0], 8'h02)
    wr(TMC_COUNT_ADDR, TMC_ZERO32);
    tick();
    tick();
    rd(TMC_COUNT_ADDR);
    `CHK(rv[7:0], 8'h02)
    tick();
    rd(TMC_COUNT_ADDR);
    `CHK(rv[7:0], TMC_BOTTOM)
    wr(TMC_CTRL_ADDR, ctl(TMC_CS_STOP, TMC_WGM_FAST, TMC_COM_OFF, 1'b0));
    wr(TMC_CMP_ADDR, 32'h0000_0044);
    rd(TMC_CMP_ADDR);
    `CHK(rv[7:0], 8'h44)
    $display("test clear-on-match done");
  endtask

  task automatic t_force();
    wr(TMC_FLAG_ADDR, 32'h0000_0003);
    for (int i = 0; i < 4; i++) begin
      wr(TMC_CTRL_ADDR, ctl(TMC_CS_STOP, TMC_WGM_NORMAL, FRC_COM[i], 1'b1));
      repeat (2) @(posedge sys_clk);
      `CHK(compare_output, FRC_OC[i])
      `CHK(compare_output_en, 1'b1)
    end
    rd(TMC_FLAG_ADDR);
    `CHK(rv[TMC_CMP_BIT], 1'b0)
    wr(TMC_CTRL_ADDR, ctl(TMC_CS_STOP, TMC_WGM_CTC, TMC_COM_TOGGLE, 1'b0));
    repeat (2) @(posedge sys_clk);
    `CHK(compare_output, 1'b1)
    wr(TMC_CTRL_ADDR, ctl(TMC_CS_STOP, TMC_WGM_NORMAL, TMC_COM_OFF, 1'b1));
    repeat (2) @(posedge sys_clk);
    `CHK(compare_output, 1'b1)
    `CHK(compare_output_en, 1'b0)
    $display("test force done");
  endtask

  // Phase correct: turn at max and at bottom, overflow at bottom
  task automatic t_pcpwm();
    wr(TMC_FLAG_ADDR, 32'h0000_0003);
    wr(TMC_CTRL_ADDR, ctl(CS_EXT_RISE, TMC_WGM_PCPWM, TMC_COM_OFF, 1'b0));
    wr(TMC_COUNT_ADDR, 32'h0000_00FE);
    tick();
    tick();
    rd(TMC_COUNT_ADDR);
    `CHK(rv[7:0], 8'hFE)
    wr(TMC_COUNT_ADDR, 32'h0000_0001);
    tick();
    tick();
    rd(TMC_COUNT_ADDR);
    `CHK(rv[7:0], 8'h01)
    rd(TMC_FLAG_ADDR);
    `CHK(rv[TMC_OVF_BIT], 1'b1)
    $display("test phase correct done");
  endtask

  // ****************************************
  // Verdict and main sequence
  // ****************************************
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    rst_n             = 1'b0;
    psel              = 1'b0;
    penable           = 1'b0;
    pwrite            = 1'b0;
    paddr             = 12'h000;
    pwdata            = 32'h0000_0000;
    ext_clk_in        = 1'b0;
    global_irq_enable = 1'b0;
    cmp_irq_ack       = 1'b0;
    ovf_irq_ack       = 1'b0;
    error_cnt         = 0;
    check_count       = 0;
    cyc               = 0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    t_reset();
    t_stop();
    t_ovf();
    t_cmp();
    t_ctc();
    t_force();
    t_pcpwm();
    end_of_test();
  end

endmodule

`default_nettype wire
